// [verilog/sbc_cache_regs.vh]
// Register offsets, field positions and codes for the segmented block cache
`ifndef SBC_CACHE_REGS_VH
`define SBC_CACHE_REGS_VH
`define SBC_A_CTRL      12'h000
`define SBC_A_STAT      12'h004
`define SBC_A_SEGSIZE   12'h008
`define SBC_A_PFMAX     12'h00c
`define SBC_A_PFCEIL    12'h010
`define SBC_A_SENSE     12'h014
`define SBC_A_HITS      12'h018
`define SBC_A_PFHITS    12'h01c
`define SBC_B_RCOFF     0
`define SBC_B_WBON      1
`define SBC_B_RAOFF     5
`define SBC_B_UPCHK     8
`define SBC_B_STICKY    2
`define SBC_SEGSIZE_RD  32'h0000ffff
`define SBC_SK_NONE     8'h00
`define SBC_SK_MEDIUM   8'h03
`define SBC_SK_HW       8'h04
`define SBC_SK_ILLEGAL  8'h05
`define SBC_ASC_POS     8'h15
`define SBC_ASC_UNCH    8'h26
`define SBC_ASC_NONE    8'h00
`define SBC_OP_READ     2'h0
`define SBC_OP_WRITE    2'h1
`define SBC_OP_FLUSH    2'h2
`define SBC_ST_GOOD     2'h0
`define SBC_ST_CHECK    2'h1
`define SBC_ST_DEFER    2'h2
`endif

// [verilog/sbc_seg_ram.v]
// Segment tag store: one registered-read memory of block tags
`timescale 1ns/1ns
`default_nettype none
module sbc_seg_ram
#(
   parameter AW = 4,
   parameter DW = 34
)
(
   input  wire          clk,    // Clock
   input  wire          we,     // Write enable
   input  wire [AW-1:0] waddr,  // Write address
   input  wire [DW-1:0] wdata,  // Write data
   input  wire [AW-1:0] raddr,  // Read address
   output reg  [DW-1:0] rdata   // Registered read data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write and registered read; a read of the address being written returns the old data
   always @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// [verilog/sbc_cache_ctrl.v]
// Segmented block cache and prefetch controller with APB registers
//
// Behaviour
// (RL1) Read cache on: look up blocks in segments before medium access.
// (RL2) Read cache off: skip lookup, read medium, segment as pass-through; lookup is skipped only when read-ahead is also off.
// (RL3) All requested blocks cached: transfer them with no medium access.
// (RL4) Any block missing: fetch into segment, then send to host.
// (RL5) Segments are circular, whole blocks, created and freed by workload.
// (RL6) Segment size field always reads all ones.
// (RL7) Segment size writes ignored; with unchangeable_param_check check flag an error.
// (RL8) Read cache on: written data stays cached for later reads.
// (RL9) Segment layout independent of read cache disable setting.
// (RL10) Write with read cache on: invalidate old copies, cache new data.
// (RL11) Write wraps in segment but stalls before overwriting uncommitted blocks.
// (RL12) Write-back on: good status once data sits in cache.
// (RL13) Failed commit of early-acknowledged data raises deferred error.
// (RL14) Flush completes only after all earlier writes are committed.
// (RL15) Prefetch on: read following blocks even with read cache off.
// (RL16) Hit on prefetched data counted as prefetch hit, not cache hit.
// (RL17) Read-ahead-off bit zero enables prefetch, one disables it.
// (RL18) Max prefetch and prefetch ceiling fields are ignored.
// (RL19) Read-ahead enabled when hit predicted, off when not.
// (RL20) Unrecoverable read reported as medium error, repeats counted once.
// (RL21) Failed seek recovery reports positioning error with hardware key.
`timescale 1ns/1ns
`default_nettype none
`include "sbc_cache_regs.vh"
module sbc_cache_ctrl
#(
   parameter SEG_AW = 4,   // log2 of segment count
   parameter LBA_W  = 32,  // Block address width
   parameter SEG_BL = 8    // Blocks per segment
)
(
   input  wire             pclk,         // Clock
   input  wire             presetn,      // Async reset, low
   input  wire             psel,         // APB select
   input  wire             penable,      // APB enable
   input  wire             pwrite,       // APB direction
   input  wire [11:0]      paddr,        // APB address
   input  wire [31:0]      pwdata,       // APB write data
   output wire             pready,       // APB ready
   output reg  [31:0]      prdata,       // APB read data
   output wire             pslverr,      // APB error
   input  wire             cmd_valid,    // Host command valid
   output wire             cmd_ready,    // Command accepted
   input  wire [1:0]       cmd_op,       // Read, write or flush
   input  wire [LBA_W-1:0] cmd_lba,      // Starting block
   output reg              done_valid,   // Completion pulse
   output reg  [1:0]       done_status,  // Good, check or deferred
   output reg              host_xfer,    // Block moved with host
   output reg              med_req,      // Medium request
   output reg              med_write,    // Medium request direction
   output reg  [LBA_W-1:0] med_lba,      // Medium block address
   input  wire             med_done,     // Medium op finished
   input  wire             med_err,      // Unrecoverable medium error
   input  wire             seek_err      // Seek recovery failed
);
   localparam NSEG = 1 << SEG_AW;
   localparam DW   = LBA_W + 2;
   // One-hot states
   localparam S_IDLE = 6'h01;
   localparam S_LOOK = 6'h02;
   localparam S_MED  = 6'h04;
   localparam S_SEND = 6'h08;
   localparam S_WR   = 6'h10;
   localparam S_FLSH = 6'h20;

   reg  [5:0]       state_reg;
   reg  [31:0]      ctrl_reg;
   reg  [7:0]       sense_reg;
   reg  [7:0]       asc_reg;
   reg  [31:0]      hits_reg;
   reg  [31:0]      pfhits_reg;
   reg  [LBA_W-1:0] lba_reg;
   reg  [1:0]       op_reg;
   reg  [SEG_AW:0]  scan_reg;
   reg  [SEG_AW-1:0] alloc_reg;
   reg  [NSEG-1:0]  valid_reg;
   reg  [NSEG-1:0]  dirty_reg;
   reg              hit_reg;
   reg              pfhit_reg;
   reg  [SEG_AW-1:0] hit_seg_reg;
   reg  [3:0]       count_reg;
   reg              pf_pred_reg;
   reg              pf_pend_reg;
   reg              med_pf_reg;
   reg              err_seen_reg;
   reg              defer_reg;
   reg  [SEG_AW-1:0] fl_seg_reg;
   reg  [3:0]       wptr_reg;
   reg  [3:0]       commit_reg;
   reg  [2:0]       sync_med_done;
   reg  [1:0]       sync_med_err;
   reg  [1:0]       sync_seek_err;
   wire             mdone = sync_med_done[1] & ~sync_med_done[2];
   wire             merr  = sync_med_err[1];
   wire             serr  = sync_seek_err[1];

   wire             rc_off  = ctrl_reg[`SBC_B_RCOFF];
   wire             wb_on   = ctrl_reg[`SBC_B_WBON];
   wire             ra_off  = ctrl_reg[`SBC_B_RAOFF];
   wire             up_chk  = ctrl_reg[`SBC_B_UPCHK];

   // Tag store: {prefetched, valid, lba}
   reg              tag_we;
   reg  [SEG_AW-1:0] tag_waddr;
   reg  [DW-1:0]    tag_wdata;
   wire [DW-1:0]    tag_rdata;
   wire [SEG_AW-1:0] scan_idx = scan_reg[SEG_AW-1:0];
   sbc_seg_ram #(.AW(SEG_AW), .DW(DW)) u_tags
   (
      .clk   (pclk),
      .we    (tag_we),
      .waddr (tag_waddr),
      .wdata (tag_wdata),
      .raddr (scan_idx),
      .rdata (tag_rdata)
   );

   // Registered read lags address by one; compare with delayed index
   reg  [SEG_AW-1:0] cmp_idx_reg;
   reg               cmp_ok_reg;
   wire tag_match = cmp_ok_reg && valid_reg[cmp_idx_reg]
                    && tag_rdata[LBA_W-1:0] == lba_reg;
   wire tag_pf    = tag_rdata[LBA_W+1];

   // APB: zero wait states, never errors
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   wire   apb_wr  = psel && penable && pwrite;
   wire   apb_rd  = psel && !penable && !pwrite;

   assign cmd_ready = (state_reg == S_IDLE);
   wire   cmd_go    = cmd_valid && cmd_ready;

   // Input synchronisers; done is used on its rising edge only
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_med_done <= 3'h0;
         sync_med_err  <= 2'h0;
         sync_seek_err <= 2'h0;
      end
      else
      begin
         sync_med_done <= {sync_med_done[1:0], med_done};
         sync_med_err  <= {sync_med_err[0], med_err};
         sync_seek_err <= {sync_seek_err[0], seek_err};
      end
   end

   // Read data mux; registered at setup phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0;
      else if (apb_rd)
      begin
         case (paddr)
            `SBC_A_CTRL:    prdata <= ctrl_reg;
            `SBC_A_STAT:    prdata <= {26'h0, state_reg};
            `SBC_A_SEGSIZE: prdata <= `SBC_SEGSIZE_RD; // RL6
            `SBC_A_PFMAX:   prdata <= 32'h0;           // RL18
            `SBC_A_PFCEIL:  prdata <= 32'h0;           // RL18
            `SBC_A_SENSE:   prdata <= {16'h0, asc_reg, sense_reg};
            `SBC_A_HITS:    prdata <= hits_reg;
            `SBC_A_PFHITS:  prdata <= pfhits_reg;
            default:        prdata <= 32'h0;
         endcase
      end
   end

   // Tag write port selection
   always @*
   begin
      tag_we    = 1'b0;
      tag_waddr = alloc_reg;
      tag_wdata = {1'b0, 1'b1, lba_reg};
      if (state_reg == S_MED && mdone && !merr && !serr)
      begin
         tag_we    = 1'b1;                            // RL5
         tag_wdata = {med_pf_reg, 1'b1, med_lba};     // RL15
      end
      else if (state_reg == S_WR && count_reg == 4'h0 && !rc_off)
         tag_we    = 1'b1;                            // RL8
   end

   // Main controller
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg    <= S_IDLE;
         ctrl_reg     <= 32'h0;
         sense_reg    <= `SBC_SK_NONE;
         asc_reg      <= `SBC_ASC_NONE;
         hits_reg     <= 32'h0;
         pfhits_reg   <= 32'h0;
         lba_reg      <= {LBA_W{1'b0}};
         op_reg       <= 2'h0;
         scan_reg     <= {(SEG_AW+1){1'b0}};
         alloc_reg    <= {SEG_AW{1'b0}};
         valid_reg    <= {NSEG{1'b0}};
         dirty_reg    <= {NSEG{1'b0}};
         hit_reg      <= 1'b0;
         pfhit_reg    <= 1'b0;
         hit_seg_reg  <= {SEG_AW{1'b0}};
         count_reg    <= 4'h0;
         pf_pred_reg  <= 1'b1;
         pf_pend_reg  <= 1'b0;
         med_pf_reg   <= 1'b0;
         err_seen_reg <= 1'b0;
         defer_reg    <= 1'b0;
         fl_seg_reg   <= {SEG_AW{1'b0}};
         wptr_reg     <= 4'h0;
         commit_reg   <= 4'h0;
         cmp_idx_reg  <= {SEG_AW{1'b0}};
         cmp_ok_reg   <= 1'b0;
         done_valid   <= 1'b0;
         done_status  <= `SBC_ST_GOOD;
         host_xfer    <= 1'b0;
         med_req      <= 1'b0;
         med_write    <= 1'b0;
         med_lba      <= {LBA_W{1'b0}};
      end
      else
      begin
         done_valid  <= 1'b0;
         host_xfer   <= 1'b0;
         cmp_idx_reg <= scan_idx;
         cmp_ok_reg  <= (state_reg == S_LOOK) && !scan_reg[SEG_AW];
         // Control writes; segment layout does not depend on cache mode
         if (apb_wr && paddr == `SBC_A_CTRL)
            ctrl_reg <= pwdata;                              // RL9 RL17
         // Segment size is fixed; unchangeable_param_check check flags the attempt
         if (apb_wr && paddr == `SBC_A_SEGSIZE && up_chk)
         begin
            sense_reg <= `SBC_SK_ILLEGAL;                    // RL7
            asc_reg   <= `SBC_ASC_UNCH;                      // RL7
         end
         // Sense clear by writing the sense register
         if (apb_wr && paddr == `SBC_A_SENSE)
         begin
            sense_reg    <= `SBC_SK_NONE;
            asc_reg      <= `SBC_ASC_NONE;
            err_seen_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE:
            begin
               if (cmd_go)
               begin
                  lba_reg  <= cmd_lba;
                  op_reg   <= cmd_op;
                  scan_reg <= {(SEG_AW+1){1'b0}};
                  hit_reg  <= 1'b0;
                  pfhit_reg <= 1'b0;
                  if (cmd_op == `SBC_OP_FLUSH)
                  begin
                     fl_seg_reg <= {SEG_AW{1'b0}};
                     state_reg  <= S_FLSH;                   // RL14
                  end
                  else if (cmd_op == `SBC_OP_READ && rc_off && ra_off)
                  begin
                     med_req    <= 1'b1;                     // RL2
                     med_write  <= 1'b0;
                     med_lba    <= cmd_lba;
                     med_pf_reg <= 1'b0;
                     state_reg  <= S_MED;
                  end
                  else
                     state_reg  <= S_LOOK;                   // RL1 RL10
               end
            end
            S_LOOK:
            begin
               if (!scan_reg[SEG_AW])
                  scan_reg <= scan_reg + 1'b1;
               if (tag_match)
               begin
                  if (op_reg == `SBC_OP_WRITE)
                     valid_reg[cmp_idx_reg] <= 1'b0;         // RL10
                  else if (!(rc_off && !tag_pf))
                  begin
                     hit_reg     <= 1'b1;
                     pfhit_reg   <= tag_pf;
                     hit_seg_reg <= cmp_idx_reg;
                  end
               end
               // Scan finished when compare pipeline drains
               if (scan_reg[SEG_AW] && !cmp_ok_reg)
               begin
                  if (op_reg == `SBC_OP_WRITE)
                  begin
                     count_reg <= SEG_BL[3:0];
                     wptr_reg  <= 4'h0;
                     commit_reg <= 4'h0;
                     state_reg <= S_WR;
                  end
                  else if (hit_reg)
                  begin
                     // Classify the hit and train read-ahead prediction
                     if (pfhit_reg)
                        pfhits_reg <= pfhits_reg + 32'h1;    // RL16
                     else
                        hits_reg   <= hits_reg + 32'h1;      // RL16
                     pf_pred_reg <= pfhit_reg;               // RL19
                     state_reg   <= S_SEND;                  // RL3
                  end
                  else
                  begin
                     med_req    <= 1'b1;                     // RL4
                     med_write  <= 1'b0;
                     med_lba    <= lba_reg;
                     med_pf_reg <= 1'b0;
                     state_reg  <= S_MED;
                  end
               end
            end
            S_MED:
            begin
               if (mdone)
               begin
                  med_req <= 1'b0;
                  if (serr)
                  begin
                     sense_reg <= `SBC_SK_HW;                // RL21
                     asc_reg   <= `SBC_ASC_POS;              // RL21
                     done_valid  <= 1'b1;
                     done_status <= `SBC_ST_CHECK;
                     state_reg   <= S_IDLE;
                  end
                  else if (merr)
                  begin
                     // Repeats before a sense clear report once
                     if (!err_seen_reg)
                     begin
                        sense_reg <= `SBC_SK_MEDIUM;         // RL20
                        asc_reg   <= `SBC_ASC_NONE;
                     end
                     err_seen_reg <= 1'b1;                   // RL20
                     done_valid  <= 1'b1;
                     done_status <= `SBC_ST_CHECK;
                     state_reg   <= S_IDLE;
                  end
                  else if (med_pf_reg)
                  begin
                     alloc_reg <= alloc_reg + 1'b1;
                     valid_reg[alloc_reg] <= 1'b1;
                     state_reg <= S_IDLE;
                  end
                  else
                  begin
                     // Dynamic segment allocation, round robin reuse
                     alloc_reg <= alloc_reg + 1'b1;          // RL5
                     valid_reg[alloc_reg] <= !rc_off;        // RL2
                     pf_pend_reg <= !ra_off && pf_pred_reg;  // RL15 RL17 RL19
                     pf_pred_reg <= 1'b0;                    // RL19
                     state_reg <= S_SEND;
                  end
               end
            end
            S_SEND:
            begin
               // Blocks leave the segment toward the host
               host_xfer   <= 1'b1;                          // RL3 RL4
               done_valid  <= 1'b1;
               done_status <= `SBC_ST_GOOD;
               if (pf_pend_reg)
               begin
                  pf_pend_reg <= 1'b0;
                  med_req     <= 1'b1;                       // RL15
                  med_write   <= 1'b0;
                  med_lba     <= lba_reg + 1'b1;
                  med_pf_reg  <= 1'b1;
                  state_reg   <= S_MED;
               end
               else
                  state_reg   <= S_IDLE;
            end
            S_WR:
            begin
               // Host fills the circular segment; commit trails behind
               if (count_reg != 4'h0 && (wptr_reg - commit_reg) < SEG_BL[3:0])
               begin
                  host_xfer <= 1'b1;
                  wptr_reg  <= wptr_reg + 4'h1;
                  count_reg <= count_reg - 4'h1;
               end                                           // RL11
               if (commit_reg != wptr_reg && mdone)
                  commit_reg <= commit_reg + 4'h1;           // RL11
               if (count_reg == 4'h0)
               begin
                  valid_reg[alloc_reg] <= !rc_off;           // RL8
                  dirty_reg[alloc_reg] <= 1'b1;
                  alloc_reg <= alloc_reg + 1'b1;
                  if (wb_on)
                  begin
                     done_valid  <= 1'b1;                    // RL12
                     done_status <= `SBC_ST_GOOD;
                     state_reg   <= S_IDLE;
                  end
                  else
                  begin
                     fl_seg_reg <= alloc_reg;
                     state_reg  <= S_FLSH;
                  end
               end
            end
            S_FLSH:
            begin
               // Flush commits each dirty segment in turn; after a write only the segment just written
               if (!dirty_reg[fl_seg_reg])
               begin
                  if (fl_seg_reg == {SEG_AW{1'b1}} || op_reg != `SBC_OP_FLUSH)
                  begin
                     done_valid  <= 1'b1;                    // RL14
                     done_status <= defer_reg ? `SBC_ST_DEFER : `SBC_ST_GOOD;
                     defer_reg   <= 1'b0;
                     state_reg   <= S_IDLE;
                  end
                  else
                     fl_seg_reg <= fl_seg_reg + 1'b1;
               end
               else if (!med_req)
               begin
                  med_req   <= 1'b1;
                  med_write <= 1'b1;
                  med_lba   <= {LBA_W{1'b0}};
               end
               else if (mdone)
               begin
                  med_req <= 1'b0;
                  dirty_reg[fl_seg_reg] <= 1'b0;
                  if (merr)
                     defer_reg <= 1'b1;                      // RL13
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [dv/sbc_cache_ctrl_properties.sv]
// Port checks for the block cache controller, bound to its top
`timescale 1ns/1ns
`default_nettype none
module sbc_cache_props
#(
   parameter LBA_W = 32
)
(
   input wire logic             pclk,        // Clock
   input wire logic             presetn,     // Reset
   input wire logic             psel,        // Select
   input wire logic             penable,     // Enable
   input wire logic             pwrite,      // Write
   input wire logic [11:0]      paddr,       // Address
   input wire logic [31:0]      pwdata,      // Wdata
   input wire logic             pready,      // Ready
   input wire logic [31:0]      prdata,      // Rdata
   input wire logic             pslverr,     // Error
   input wire logic             cmd_valid,   // Command
   input wire logic             cmd_ready,   // Taken
   input wire logic [1:0]       cmd_op,      // Op
   input wire logic [LBA_W-1:0] cmd_lba,     // Start
   input wire logic             done_valid,  // Done
   input wire logic [1:0]       done_status, // Status
   input wire logic             host_xfer,   // Moved
   input wire logic             med_req,     // Request
   input wire logic             med_write,   // Dir
   input wire logic [LBA_W-1:0] med_lba,     // Block
   input wire logic             med_done,    // Answer
   input wire logic             med_err,     // Fault
   input wire logic             seek_err     // Seek
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Read setup cycle loads prdata for the access cycle
   wire rd_setup = psel & ~penable & ~pwrite;
   wire taken    = cmd_valid & cmd_ready;
   a_apb_no_wait: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb stall or error");
   a_size_ones: assert property (rd_setup && paddr == 12'h008 |=> prdata == 32'h0000ffff)
      else $error("segment size not all ones");
   a_pf_fields_zero: assert property (rd_setup && (paddr == 12'h00c || paddr == 12'h010)
      |=> prdata == 32'h0)
      else $error("prefetch field not ignored");
   a_one_at_time: assert property (taken |=> !cmd_ready)
      else $error("second command taken");
   a_done_bounded: assert property (taken |-> ##[2:1000] done_valid)
      else $error("command never completed");
   a_done_pulse: assert property (done_valid |=> !done_valid)
      else $error("completion longer than one cycle");
   a_req_held: assert property (med_req && !med_done |=> med_req)
      else $error("medium request dropped early");
   a_req_stable: assert property (med_req && $past(med_req) |-> $stable(med_lba))
      else $error("medium address moved");
   c_good: cover property (done_valid && done_status == 2'h0);
   c_check: cover property (done_valid && done_status == 2'h1);
   c_defer: cover property (done_valid && done_status == 2'h2);
endmodule
bind sbc_cache_ctrl sbc_cache_props #(.LBA_W(LBA_W)) sbc_cache_props_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .cmd_valid,
   .cmd_ready, .cmd_op, .cmd_lba, .done_valid, .done_status, .host_xfer, .med_req,
   .med_write, .med_lba, .med_done, .med_err, .seek_err);
`default_nettype wire

// [dv/sbc_medium_model.sv]
// Behavioural medium that answers requests, with faults on command
`timescale 1ns/1ns
`default_nettype none
module sbc_medium_model
#(
   parameter DLY = 5
)
(
   input  wire logic pclk,      // Clock
   input  wire logic presetn,   // Reset
   input  wire logic med_req,   // Request
   input  wire logic med_write, // Dir
   input  wire logic fail_rd,   // Fail reads
   input  wire logic fail_wr,   // Fail writes
   input  wire logic fail_seek, // Fail seeks
   output var  logic med_done,  // Answer
   output var  logic med_err,   // Fault
   output var  logic seek_err   // Seek fault
);
   // Answer held four cycles so the two-flop sync catches it
   initial
   begin
      med_done = 1'b0;
      med_err = 1'b0;
      seek_err = 1'b0;
      forever
      begin
         @(posedge pclk);
         if (presetn && med_req)
         begin
            repeat (DLY) @(posedge pclk);
            med_done <= 1'b1;
            med_err <= med_write ? fail_wr : fail_rd;
            seek_err <= fail_seek & ~med_write;
            repeat (4) @(posedge pclk);
            med_done <= 1'b0;
            med_err <= 1'b0;
            seek_err <= 1'b0;
            repeat (2) @(posedge pclk);
         end
      end
   end
endmodule
`default_nettype wire

// [dv/test_sbc_cache_ctrl.sv]
// Self-checking bench for the block cache controller
`timescale 1ns/1ns
`default_nettype none
`include "sbc_cache_regs.vh"
module test_sbc_cache_ctrl;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cmd_valid = 1'b0, fail_rd = 1'b0, fail_wr = 1'b0, fail_seek = 1'b0;
   logic        med_q = 1'b0, pready, pslverr, cmd_ready, done_valid, host_xfer;
   logic        med_req, med_write, med_done, med_err, seek_err;
   logic [1:0]  cmd_op = 2'h0, done_status;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, cmd_lba = 32'h0, prdata, med_lba, q, st;
   integer      error_cnt = 0, n_compared = 0, med_n = 0, wr_n = 0, xfer_n = 0;
   sbc_cache_ctrl sbc_cache_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .cmd_valid, .cmd_ready, .cmd_op, .cmd_lba,
      .done_valid, .done_status, .host_xfer, .med_req, .med_write, .med_lba, .med_done,
      .med_err, .seek_err);
   sbc_medium_model sbc_medium_model_i (.pclk, .presetn, .med_req, .med_write, .fail_rd,
      .fail_wr, .fail_seek, .med_done, .med_err, .seek_err);
   // 25 MHz clock
   initial forever #20 pclk = ~pclk;
   // Counted on the falling edge, clear of the design's own updates
   always @(negedge pclk)
   begin
      med_n <= med_n + 32'(med_req & ~med_q);
      wr_n <= wr_n + 32'(med_req & ~med_q & med_write);
      xfer_n <= xfer_n + 32'(host_xfer);
      med_q <= med_req;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; read data lands in q
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // One host command; waits for completion, status lands in st
   task cmd(input logic [1:0] op, input logic [31:0] lba);
      med_n = 0;
      wr_n = 0;
      xfer_n = 0;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_lba <= lba;
      @(posedge pclk);
      while (cmd_ready !== 1'b1) @(posedge pclk);
      cmd_valid <= 1'b0;
      @(posedge pclk);
      while (done_valid !== 1'b1) @(posedge pclk);
      st = {30'h0, done_status};
      repeat (2) @(posedge pclk);
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole run is a few hundred cycles; a hang ends here
   initial
   begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      finish_test;
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `SBC_A_CTRL, 32'h0);
      check(q, 32'h0);
      apb(1'b1, `SBC_A_PFMAX, 32'h00000040);
      apb(1'b0, `SBC_A_PFMAX, 32'h0);
      check(q, 32'h0);
      apb(1'b1, `SBC_A_CTRL, 32'h00000120);
      apb(1'b1, `SBC_A_SEGSIZE, 32'h00000010);
      apb(1'b0, `SBC_A_SENSE, 32'h0);
      check(q, {16'h0, `SBC_ASC_UNCH, `SBC_SK_ILLEGAL});
      apb(1'b1, `SBC_A_SENSE, 32'h0);
      cmd(`SBC_OP_READ, 32'h00000100);
      check(32'(med_n != 0), 32'h1);
      cmd(`SBC_OP_READ, 32'h00000100);
      check(med_n, 32'h0);
      cmd(`SBC_OP_WRITE, 32'h00000100);
      check(xfer_n, 32'h8);
      check(32'(wr_n != 0), 32'h1);
      cmd(`SBC_OP_READ, 32'h00000100);
      check(med_n, 32'h0);
      apb(1'b1, `SBC_A_CTRL, 32'h00000121);
      cmd(`SBC_OP_READ, 32'h00000100);
      check(32'(med_n != 0), 32'h1);
      apb(1'b0, `SBC_A_SEGSIZE, 32'h0);
      check(q, `SBC_SEGSIZE_RD);
      apb(1'b1, `SBC_A_CTRL, 32'h00000122);
      cmd(`SBC_OP_WRITE, 32'h00000200);
      check(st, 32'h0);
      check(wr_n, 32'h0);
      fail_wr <= 1'b1;
      cmd(`SBC_OP_FLUSH, 32'h0);
      check(st, 32'h2);
      check(32'(wr_n != 0), 32'h1);
      fail_rd <= 1'b1;
      cmd(`SBC_OP_READ, 32'h00000400);
      check(st, 32'h1);
      apb(1'b0, `SBC_A_SENSE, 32'h0);
      check({24'h0, q[7:0]}, {24'h0, `SBC_SK_MEDIUM});
      apb(1'b1, `SBC_A_SEGSIZE, 32'h0);
      cmd(`SBC_OP_READ, 32'h00000500);
      apb(1'b0, `SBC_A_SENSE, 32'h0);
      check(q, {16'h0, `SBC_ASC_UNCH, `SBC_SK_ILLEGAL});
      fail_rd <= 1'b0;
      apb(1'b1, `SBC_A_SENSE, 32'h0);
      fail_seek <= 1'b1;
      cmd(`SBC_OP_READ, 32'h00000600);
      check(st, 32'h1);
      apb(1'b0, `SBC_A_SENSE, 32'h0);
      check(q, {16'h0, `SBC_ASC_POS, `SBC_SK_HW});
      apb(1'b0, `SBC_A_PFHITS, 32'h0);
      check(q, 32'h0);
      fail_seek <= 1'b0;
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmd(`SBC_OP_READ, 32'h00000700);
      check(med_n, 32'h2);
      cmd(`SBC_OP_READ, 32'h00000701);
      apb(1'b0, `SBC_A_PFHITS, 32'h0);
      check(q, 32'h1);
      finish_test;
   end
endmodule
`default_nettype wire
